// ===== core/video_timing_pkg.sv
// constants shared by the window generator and the timing measurer
package video_timing_pkg;

   // ****************************************************************
   // register offsets
   // ****************************************************************
   localparam logic [7:0] ADDR_CONTROL          = 8'h00;
   localparam logic [7:0] ADDR_EMPHASIS         = 8'h0B;
   localparam logic [7:0] ADDR_HWIN_START_LO    = 8'h0F;
   localparam logic [7:0] ADDR_HWIN_START_HI    = 8'h10;
   localparam logic [7:0] ADDR_HWIN_LENGTH_LO   = 8'h11;
   localparam logic [7:0] ADDR_HWIN_LENGTH_HI   = 8'h12;
   localparam logic [7:0] ADDR_VWIN_START_LO    = 8'h13;
   localparam logic [7:0] ADDR_VWIN_START_HI    = 8'h14;
   localparam logic [7:0] ADDR_VWIN_LENGTH_LO   = 8'h15;
   localparam logic [7:0] ADDR_VWIN_LENGTH_HI   = 8'h16;
   localparam logic [7:0] ADDR_H_FRONT_LO       = 8'h17;
   localparam logic [7:0] ADDR_H_FRONT_HI       = 8'h18;
   localparam logic [7:0] ADDR_H_PULSE_LO       = 8'h19;
   localparam logic [7:0] ADDR_H_PULSE_HI       = 8'h1A;
   localparam logic [7:0] ADDR_H_BACK_LO        = 8'h1B;
   localparam logic [7:0] ADDR_H_BACK_HI        = 8'h1C;
   localparam logic [7:0] ADDR_V_FRONT_LO       = 8'h1D;
   localparam logic [7:0] ADDR_V_FRONT_HI       = 8'h1E;
   localparam logic [7:0] ADDR_V_PULSE          = 8'h1F;
   localparam logic [7:0] ADDR_V_BACK_LO        = 8'h20;
   localparam logic [7:0] ADDR_V_BACK_HI        = 8'h21;
   localparam logic [7:0] ADDR_PREV_V_FRONT_LO  = 8'h22;
   localparam logic [7:0] ADDR_PREV_V_FRONT_HI  = 8'h23;
   localparam logic [7:0] ADDR_PREV_V_PULSE     = 8'h24;

   // ****************************************************************
   // field positions and reset values
   // ****************************************************************
   localparam int          CTRL_VD_ENABLE_BIT   = 3;
   localparam int          CTRL_HREF_SEL_BIT    = 6;
   localparam int          CTRL_VD_RESET_BIT    = 7;
   localparam int          EMPH_INSIDE_SEL_BIT  = 7;
   localparam logic [7:0]  CONTROL_RESET        = 8'h00;
   localparam logic [7:0]  EMPHASIS_RESET       = 8'h00;
   localparam logic [10:0] WIN_FIELD_RESET      = 11'h000;
   localparam logic [10:0] MEAS11_RESET         = 11'h000;
   localparam logic [9:0]  MEAS10_RESET         = 10'h000;
   localparam logic [7:0]  MEAS8_RESET          = 8'h00;
   localparam logic [11:0] COUNT_RESET          = 12'h000;
   localparam logic [11:0] COUNT_MAX            = 12'hFFF;

endpackage

// ===== core/pin_sync_edge.sv
// two-stage synchroniser for a pin with leading and trailing edge pulses
`timescale 1ns/1ps

module pin_sync_edge (
   input  wire logic mclk,
   input  wire logic reset_n,
   input  wire logic pin_in,
   output logic      level,
   output logic      lead,
   output logic      trail
);

   typedef struct packed {
      logic meta;
      logic sync;
      logic last;
   } state_s;

   state_s q;
   state_s d;

   // ****************************************************************
   // sync chain; only the second stage and later feed logic
   // ****************************************************************
   always_comb begin
      d      = q;
      d.meta = pin_in;
      d.sync = q.meta;
      d.last = q.sync;
   end

   always_ff @(posedge mclk or negedge reset_n) begin
      if (!reset_n) begin
         q <= '0;
      end else begin
         q <= d;
      end
   end

   assign level = q.sync;
   assign lead  = q.sync & ~q.last;
   assign trail = ~q.sync & q.last;

endmodule

// ===== core/porch_min_tracker.sv
// holds the smallest porch count seen since the last clear
`timescale 1ns/1ps

module porch_min_tracker (
   input  wire logic        mclk,
   input  wire logic        reset_n,
   input  wire logic        clear,
   input  wire logic        load,
   input  wire logic [10:0] candidate,
   output logic      [10:0] value
);

   typedef struct packed {
      logic        valid;
      logic [10:0] value;
   } state_s;

   state_s q;
   state_s d;

   // ****************************************************************
   // minimum update
   // ****************************************************************
   // the first sample after a clear is taken as is, since zero is the
   // cleared value and would otherwise never be beaten
   always_comb begin
      d = q;
      if (clear) begin
         d.valid = 1'b0;
         d.value = video_timing_pkg::MEAS11_RESET;
      end else if (load && (!q.valid || candidate < q.value)) begin
         d.valid = 1'b1;
         d.value = candidate;
      end
   end

   always_ff @(posedge mclk or negedge reset_n) begin
      if (!reset_n) begin
         q <= '0;
      end else begin
         q <= d;
      end
   end

   assign value = q.value;

endmodule

// ===== core/video_window_timing_measure.sv
// highlight window generator and video detect timing measurer
`timescale 1ns/1ps

// Summary of operation
// - window starts programmed pixels after horizontal reference leading edge.
// - window lasts programmed pixels; zero width disables the window.
// - window starts programmed lines after vertical sync leading edge.
// - window lasts programmed lines; zero length disables the window.
// - smallest horizontal front porch in pixels kept; zero with no video.
// - selected horizontal pulse width captured in pixels, ten bits.
// - smallest horizontal back porch kept; without video it spans rest of line.
// - smallest vertical front porch in lines kept; zero with no video.
// - vertical sync width captured in line periods, eight bits.
// - smallest vertical back porch kept; without video it spans rest of field.
// - previous field's vertical front porch kept separately; zero with no video.
// - every measured register clears to zero on video detect reset.
// - previous field's vertical sync width kept, cleared by video detect reset.
// - control bit picks horizontal sync (zero) or retrace pulse (one).
// - video detect reset bit clears measurements then returns to zero itself.
// - select bit zero puts second input inside window, first outside.
module video_window_timing_measure (
   input  wire logic       mclk,
   input  wire logic       reset_n,
   input  wire logic       hsync_in,
   input  wire logic       h_retrace_pulse_in,
   input  wire logic       vsync_in,
   input  wire logic       video_present_in,
   input  wire logic [7:0] reg_addr,
   input  wire logic [7:0] reg_wdata,
   input  wire logic       reg_wr,
   input  wire logic       reg_rd,
   output logic      [7:0] reg_rdata,
   output logic            window_active,
   output logic            source_b_select
);

   typedef struct packed {
      logic [7:0]  control;
      logic [7:0]  emphasis;
      logic [10:0] hwin_start;
      logic [10:0] hwin_length;
      logic [10:0] vwin_start;
      logic [10:0] vwin_length;
      logic [11:0] h_cnt;
      logic [11:0] v_cnt;
      logic        h_armed;
      logic        line_saw;
      logic [11:0] first_pos;
      logic [11:0] last_pos;
      logic [11:0] trail_pos;
      logic        v_armed;
      logic        field_saw;
      logic [11:0] first_line;
      logic [11:0] last_line;
      logic [11:0] trail_line;
      logic [9:0]  h_pulse_width;
      logic [7:0]  v_pulse_width;
      logic [7:0]  prev_v_pulse_width;
      logic [10:0] prev_v_front_porch;
      logic [7:0]  rdata;
      logic        win;
      logic        src_b;
   } state_s;

   state_s q;
   state_s d;

   logic        hs_lvl, hs_lead, hs_trail;
   logic        hr_lvl, hr_lead, hr_trail;
   logic        vs_lvl, vs_lead, vs_trail;
   logic        vid_lvl;
   logic        href_lvl, href_lead, href_trail;
   logic        vd_clear, vd_enable;
   logic        hfp_load, hbp_load, vfp_load, vbp_load;
   logic [10:0] hfp_cand, hbp_cand, vfp_cand, vbp_cand;
   logic [10:0] hfp_val, hbp_val, vfp_val, vbp_val;
   logic        h_in, v_in;

   // ****************************************************************
   // helpers
   // ****************************************************************
   function automatic logic [11:0] inc_sat(input logic [11:0] v);
      return (v == video_timing_pkg::COUNT_MAX) ? v : v + 12'h001;
   endfunction

   // clamped difference, saturated to the 11-bit register width
   function automatic logic [10:0] diff11(input logic [11:0] a, input logic [11:0] b);
      logic [11:0] r;
      r = (a > b) ? a - b : 12'h000;
      return r[11] ? 11'h7FF : r[10:0];
   endfunction

   function automatic logic in_range(input logic [11:0] cnt, input logic [10:0] start,
                                     input logic [10:0] len);
      return (len != 11'h000) && (cnt >= {1'b0, start}) &&
             (cnt < ({1'b0, start} + {1'b0, len}));
   endfunction

   // ****************************************************************
   // pin synchronisers
   // ****************************************************************
   pin_sync_edge u_hsync (
      .mclk    (mclk),
      .reset_n (reset_n),
      .pin_in  (hsync_in),
      .level   (hs_lvl),
      .lead    (hs_lead),
      .trail   (hs_trail)
   );

   pin_sync_edge u_hretrace (
      .mclk    (mclk),
      .reset_n (reset_n),
      .pin_in  (h_retrace_pulse_in),
      .level   (hr_lvl),
      .lead    (hr_lead),
      .trail   (hr_trail)
   );

   pin_sync_edge u_vsync (
      .mclk    (mclk),
      .reset_n (reset_n),
      .pin_in  (vsync_in),
      .level   (vs_lvl),
      .lead    (vs_lead),
      .trail   (vs_trail)
   );

   pin_sync_edge u_video (
      .mclk    (mclk),
      .reset_n (reset_n),
      .pin_in  (video_present_in),
      .level   (vid_lvl),
      .lead    (),
      .trail   ()
   );

   // switching the reference mid-line may give one bad line; the host
   // resets video detect after changing it anyway
   assign href_lvl   = q.control[video_timing_pkg::CTRL_HREF_SEL_BIT] ? hr_lvl : hs_lvl;
   assign href_lead  = q.control[video_timing_pkg::CTRL_HREF_SEL_BIT] ? hr_lead : hs_lead;
   assign href_trail = q.control[video_timing_pkg::CTRL_HREF_SEL_BIT] ? hr_trail : hs_trail;

   // detect reset acts at its write edge, so the bit never reads back as one
   assign vd_clear  = reg_wr && (reg_addr == video_timing_pkg::ADDR_CONTROL)
                      && reg_wdata[video_timing_pkg::CTRL_VD_RESET_BIT];
   assign vd_enable = q.control[video_timing_pkg::CTRL_VD_ENABLE_BIT];

   // ****************************************************************
   // porch minima
   // ****************************************************************
   always_comb begin
      hfp_cand = diff11(q.h_cnt, q.last_pos);
      hfp_load = vd_enable && href_lead && q.h_armed && q.line_saw;
      hbp_cand = q.line_saw ? diff11(q.first_pos, q.trail_pos)
                            : diff11(q.h_cnt, q.trail_pos);
      hbp_load = vd_enable && href_lead && q.h_armed;
      vfp_cand = diff11(q.v_cnt, q.last_line);
      vfp_load = vd_enable && vs_lead && q.v_armed && q.field_saw;
      vbp_cand = q.field_saw ? diff11(q.first_line, q.trail_line)
                             : diff11(q.v_cnt, q.trail_line);
      vbp_load = vd_enable && vs_lead && q.v_armed;
   end

   porch_min_tracker u_hfp (
      .mclk      (mclk),
      .reset_n   (reset_n),
      .clear     (vd_clear),
      .load      (hfp_load),
      .candidate (hfp_cand),
      .value     (hfp_val)
   );

   porch_min_tracker u_hbp (
      .mclk      (mclk),
      .reset_n   (reset_n),
      .clear     (vd_clear),
      .load      (hbp_load),
      .candidate (hbp_cand),
      .value     (hbp_val)
   );

   porch_min_tracker u_vfp (
      .mclk      (mclk),
      .reset_n   (reset_n),
      .clear     (vd_clear),
      .load      (vfp_load),
      .candidate (vfp_cand),
      .value     (vfp_val)
   );

   porch_min_tracker u_vbp (
      .mclk      (mclk),
      .reset_n   (reset_n),
      .clear     (vd_clear),
      .load      (vbp_load),
      .candidate (vbp_cand),
      .value     (vbp_val)
   );

   // ****************************************************************
   // next state
   // ****************************************************************
   always_comb begin
      d = q;
      // pixel and line counters on the pixel clock
      d.h_cnt = href_lead ? video_timing_pkg::COUNT_RESET : inc_sat(q.h_cnt);
      if (vs_lead) begin
         d.v_cnt = video_timing_pkg::COUNT_RESET;
      end else if (href_lead) begin
         d.v_cnt = inc_sat(q.v_cnt);
      end

      // video seen within the line, outside the horizontal pulse
      if (vid_lvl && !href_lvl && q.h_armed) begin
         if (!q.line_saw) begin
            d.first_pos = q.h_cnt;
         end
         d.last_pos = q.h_cnt;
         d.line_saw = 1'b1;
      end

      if (href_trail) begin
         d.trail_pos = q.h_cnt;
         d.h_armed   = 1'b1;
         if (vd_enable) begin
            d.h_pulse_width = q.h_cnt >= 12'h3FF ? 10'h3FF : q.h_cnt[9:0] + 10'h001;
         end
      end

      if (href_lead) begin
         d.line_saw = 1'b0;
         if (q.line_saw && q.v_armed) begin
            if (!q.field_saw) begin
               d.first_line = q.v_cnt;
            end
            d.last_line = q.v_cnt;
            d.field_saw = 1'b1;
         end
      end

      if (vs_trail) begin
         d.trail_line = q.v_cnt;
         d.v_armed    = 1'b1;
         if (vd_enable) begin
            d.v_pulse_width = q.v_cnt >= 12'h0FF ? 8'hFF : q.v_cnt[7:0] + 8'h01;
         end
      end

      if (vs_lead) begin
         d.field_saw = 1'b0;
         if (vd_enable && q.v_armed) begin
            d.prev_v_pulse_width = q.v_pulse_width;
            d.prev_v_front_porch = q.field_saw ? vfp_cand
                                               : video_timing_pkg::MEAS11_RESET;
         end
      end

      // video detect reset: all results and arming back to zero
      if (vd_clear) begin
         d.h_armed            = 1'b0;
         d.v_armed            = 1'b0;
         d.line_saw           = 1'b0;
         d.field_saw          = 1'b0;
         d.h_pulse_width      = video_timing_pkg::MEAS10_RESET;
         d.v_pulse_width      = video_timing_pkg::MEAS8_RESET;
         d.prev_v_pulse_width = video_timing_pkg::MEAS8_RESET;
         d.prev_v_front_porch = video_timing_pkg::MEAS11_RESET;
      end

      // window: both counters inside their ranges
      h_in  = in_range(q.h_cnt, q.hwin_start, q.hwin_length);
      v_in  = in_range(q.v_cnt, q.vwin_start, q.vwin_length);
      d.win = h_in && v_in;
      d.src_b = (h_in && v_in) ^ q.emphasis[video_timing_pkg::EMPH_INSIDE_SEL_BIT];

      // register writes, low byte then upper bits at the next address
      if (reg_wr) begin
         unique case (reg_addr)
            video_timing_pkg::ADDR_CONTROL:
               d.control = reg_wdata & ~(8'h01 << video_timing_pkg::CTRL_VD_RESET_BIT);
            video_timing_pkg::ADDR_EMPHASIS:       d.emphasis = reg_wdata;
            video_timing_pkg::ADDR_HWIN_START_LO:  d.hwin_start[7:0] = reg_wdata;
            video_timing_pkg::ADDR_HWIN_START_HI:  d.hwin_start[10:8] = reg_wdata[2:0];
            video_timing_pkg::ADDR_HWIN_LENGTH_LO: d.hwin_length[7:0] = reg_wdata;
            video_timing_pkg::ADDR_HWIN_LENGTH_HI: d.hwin_length[10:8] = reg_wdata[2:0];
            video_timing_pkg::ADDR_VWIN_START_LO:  d.vwin_start[7:0] = reg_wdata;
            video_timing_pkg::ADDR_VWIN_START_HI:  d.vwin_start[10:8] = reg_wdata[2:0];
            video_timing_pkg::ADDR_VWIN_LENGTH_LO: d.vwin_length[7:0] = reg_wdata;
            video_timing_pkg::ADDR_VWIN_LENGTH_HI: d.vwin_length[10:8] = reg_wdata[2:0];
            default: ;
         endcase
      end

      // register reads; upper unused bits read zero
      if (reg_rd) begin
         unique case (reg_addr)
            video_timing_pkg::ADDR_CONTROL:         d.rdata = q.control;
            video_timing_pkg::ADDR_EMPHASIS:        d.rdata = q.emphasis;
            video_timing_pkg::ADDR_HWIN_START_LO:   d.rdata = q.hwin_start[7:0];
            video_timing_pkg::ADDR_HWIN_START_HI:   d.rdata = {5'h00, q.hwin_start[10:8]};
            video_timing_pkg::ADDR_HWIN_LENGTH_LO:  d.rdata = q.hwin_length[7:0];
            video_timing_pkg::ADDR_HWIN_LENGTH_HI:  d.rdata = {5'h00, q.hwin_length[10:8]};
            video_timing_pkg::ADDR_VWIN_START_LO:   d.rdata = q.vwin_start[7:0];
            video_timing_pkg::ADDR_VWIN_START_HI:   d.rdata = {5'h00, q.vwin_start[10:8]};
            video_timing_pkg::ADDR_VWIN_LENGTH_LO:  d.rdata = q.vwin_length[7:0];
            video_timing_pkg::ADDR_VWIN_LENGTH_HI:  d.rdata = {5'h00, q.vwin_length[10:8]};
            video_timing_pkg::ADDR_H_FRONT_LO:      d.rdata = hfp_val[7:0];
            video_timing_pkg::ADDR_H_FRONT_HI:      d.rdata = {5'h00, hfp_val[10:8]};
            video_timing_pkg::ADDR_H_PULSE_LO:      d.rdata = q.h_pulse_width[7:0];
            video_timing_pkg::ADDR_H_PULSE_HI:      d.rdata = {6'h00, q.h_pulse_width[9:8]};
            video_timing_pkg::ADDR_H_BACK_LO:       d.rdata = hbp_val[7:0];
            video_timing_pkg::ADDR_H_BACK_HI:       d.rdata = {5'h00, hbp_val[10:8]};
            video_timing_pkg::ADDR_V_FRONT_LO:      d.rdata = vfp_val[7:0];
            video_timing_pkg::ADDR_V_FRONT_HI:      d.rdata = {5'h00, vfp_val[10:8]};
            video_timing_pkg::ADDR_V_PULSE:         d.rdata = q.v_pulse_width;
            video_timing_pkg::ADDR_V_BACK_LO:       d.rdata = vbp_val[7:0];
            video_timing_pkg::ADDR_V_BACK_HI:       d.rdata = {5'h00, vbp_val[10:8]};
            video_timing_pkg::ADDR_PREV_V_FRONT_LO: d.rdata = q.prev_v_front_porch[7:0];
            video_timing_pkg::ADDR_PREV_V_FRONT_HI: d.rdata = {5'h00, q.prev_v_front_porch[10:8]};
            video_timing_pkg::ADDR_PREV_V_PULSE:    d.rdata = q.prev_v_pulse_width;
            default:                                d.rdata = 8'h00;
         endcase
      end
   end

   // ****************************************************************
   // state register
   // ****************************************************************
   always_ff @(posedge mclk or negedge reset_n) begin
      if (!reset_n) begin
         q          <= '0;
         q.control  <= video_timing_pkg::CONTROL_RESET;
         q.emphasis <= video_timing_pkg::EMPHASIS_RESET;
      end else begin
         q <= d;
      end
   end

   assign reg_rdata       = q.rdata;
   assign window_active   = q.win;
   assign source_b_select = q.src_b;

endmodule

// ===== dv/video_window_timing_measure_assertions.sv
// assertion checker for the window generator and timing measurer ports
`timescale 1ns/1ps
module vwtm_checker (
   input wire logic       mclk,
   input wire logic       reset_n,
   input wire logic       hsync_in,
   input wire logic [7:0] reg_addr,
   input wire logic [7:0] reg_wdata,
   input wire logic       reg_wr,
   input wire logic       reg_rd,
   input wire logic [7:0] reg_rdata,
   input wire logic       window_active,
   input wire logic       source_b_select
);
   // ****************************************
   // register shadow, run and position counters
   // ****************************************
   logic [95:0] sh_q;
   logic [10:0] wrun_q;
   logic [11:0] hpos_q;
   logic        hs_q;
   wire  [10:0] hstart = {sh_q[42:40], sh_q[39:32]};
   wire  [10:0] hlen   = {sh_q[58:56], sh_q[55:48]};
   wire  [10:0] vlen   = {sh_q[90:88], sh_q[87:80]};
   always_ff @(posedge mclk or negedge reset_n) begin
      if (!reset_n) begin
         sh_q   <= '0;
         wrun_q <= '0;
         hpos_q <= '0;
         hs_q   <= 1'b0;
      end else begin
         if (reg_wr && reg_addr >= 8'h0B && reg_addr <= 8'h16) sh_q[(reg_addr - 8'h0B) * 8 +: 8] <= reg_wdata;
         wrun_q <= window_active ? wrun_q + 11'h001 : 11'h000;
         hpos_q <= (hsync_in && !hs_q) ? 12'h000 : hpos_q + 12'h001;
         hs_q   <= hsync_in;
      end
   end
   // ****************************************
   // properties
   // ****************************************
   default clocking cb @(posedge mclk); endclocking
   default disable iff (!reset_n);
   a_rdata_holds: assert property (!reg_rd |=> $stable(reg_rdata))
      else $error("read data moved without a read strobe");
   a_unmapped_zero: assert property (reg_rd && reg_addr > 8'h24 |=> reg_rdata == 8'h00)
      else $error("unmapped read not zero");
   a_rw_readback: assert property (reg_wr && reg_addr == 8'h0F ##1 reg_rd && !reg_wr && reg_addr == 8'h0F
      |=> reg_rdata == $past(reg_wdata, 2)) else $error("start field readback wrong");
   a_vdreset_clears: assert property (reg_wr && reg_addr == 8'h00 && reg_wdata[7]
      ##1 reg_rd && reg_addr inside {[8'h17:8'h24]} |=> reg_rdata == 8'h00) else $error("measurement not cleared");
   a_reset_selfclear: assert property (reg_wr && reg_addr == 8'h00 && reg_wdata[7]
      ##1 reg_rd && reg_addr == 8'h00 |=> !reg_rdata[7]) else $error("detect reset bit stuck");
   a_hzero_off: assert property ((hlen == 11'h000) [*4] |-> !window_active)
      else $error("window with zero width");
   a_vzero_off: assert property ((vlen == 11'h000) [*4] |-> !window_active)
      else $error("window with zero length");
   a_win_start: assert property ($rose(window_active)
      |-> hpos_q >= 12'(hstart) + 12'h002 && hpos_q <= 12'(hstart) + 12'h007) else $error("window start misplaced");
   a_win_width: assert property (window_active && hlen != 11'h000 |-> wrun_q < hlen)
      else $error("window longer than width");
   a_src_select: assert property ($stable(sh_q[7]) |-> source_b_select == (window_active ^ sh_q[7]))
      else $error("source select wrong");
   c_window_on: cover property ($rose(window_active));
   c_vd_reset: cover property (reg_wr && reg_addr == 8'h00 && reg_wdata[7]);
   c_select_inv: cover property (source_b_select && !window_active);
endmodule
bind video_window_timing_measure vwtm_checker vwtm_checker_i (.*);

// ===== dv/video_source_model.sv
// behavioural video source: sync, retrace, video level
`timescale 1ns/1ps
module video_source_model #(
   parameter int H_TOTAL = 100,
   parameter int H_SYNC  = 8,
   parameter int H_RETR  = 12,
   parameter int H_VON   = 30,
   parameter int H_VOFF  = 90,
   parameter int V_TOTAL = 20,
   parameter int V_SYNC  = 2,
   parameter int V_VON   = 5,
   parameter int V_VOFF  = 17
) (
   input  wire logic mclk,
   input  wire logic video_en,
   output logic      hsync,
   output logic      retrace,
   output logic      vsync,
   output logic      video
);
   int hc = 0;
   int vc = 0;
   // sync and retrace leads coincide
   always @(negedge mclk) begin
      hc <= (hc == H_TOTAL - 1) ? 0 : hc + 1;
      if (hc == H_TOTAL - 1) vc <= (vc == V_TOTAL - 1) ? 0 : vc + 1;
   end
   assign hsync   = hc < H_SYNC;
   assign retrace = hc < H_RETR;
   assign vsync   = vc < V_SYNC;
   assign video   = video_en && hc >= H_VON && hc < H_VOFF && vc >= V_VON && vc < V_VOFF;
endmodule

// ===== dv/tb_top.sv
// self-checking bench for the window generator and timing measurer
`timescale 1ns/1ps
module tb_top;
   localparam int HT = 100, HS = 8, HR = 12, HON = 30, HOFF = 90;
   localparam int VT = 20, VS = 2, VON = 5, VOFF = 17, FIELD = HT * VT;
   logic       mclk = 1'b0;
   logic       reset_n = 1'b0;
   logic       video_en = 1'b1;
   logic       hsync_in, h_retrace_pulse_in, vsync_in, video_present_in;
   logic [7:0] reg_addr = 8'h00;
   logic [7:0] reg_wdata = 8'h00;
   logic       reg_wr = 1'b0;
   logic       reg_rd = 1'b0;
   logic [7:0] reg_rdata;
   logic       window_active, source_b_select;
   int         err_count = 0;
   int         n_compared = 0;
   initial forever #4 mclk = ~mclk;
   // model defaults match the localparams above
   video_source_model video_source_model_i (.mclk(mclk), .video_en(video_en),
      .hsync(hsync_in), .retrace(h_retrace_pulse_in), .vsync(vsync_in), .video(video_present_in));
   video_window_timing_measure video_window_timing_measure_i (.*);
   // ****************************************
   // shared tasks
   // ****************************************
   task automatic chk(input string name, input logic [15:0] seen, input int exp, input int tol);
      n_compared++;
      if ((^seen === 1'bx) || int'(seen) < exp - tol || int'(seen) > exp + tol) begin
         err_count++;
         $display("Error %s expected %0d seen %0d", name, exp, seen);
      end
   endtask
   task automatic wr(input logic [7:0] a, input logic [7:0] d);
      reg_addr = a;
      reg_wdata = d;
      reg_wr = 1'b1;
      @(negedge mclk);
      reg_wr = 1'b0;
   endtask
   task automatic wr16(input logic [7:0] a, input int val);
      wr(a, 8'(val));
      wr(a + 8'h01, 8'(val >> 8));
   endtask
   // wide read: strobe stays up, upper byte next cycle
   task automatic rd(input logic [7:0] a, input bit wide, output logic [15:0] v);
      reg_addr = a;
      reg_rd = 1'b1;
      @(negedge mclk);
      v = {8'h00, reg_rdata};
      if (wide) begin
         reg_addr = a + 8'h01;
         @(negedge mclk);
         v[15:8] = reg_rdata;
      end
      reg_rd = 1'b0;
   endtask
   task automatic measure(input logic [7:0] ctrl, input int hpw, input bit vid);
      logic [15:0] v, hp, vp;
      video_en = vid;
      wr(8'h00, ctrl);
      repeat (3 * FIELD) @(negedge mclk);
      rd(8'h17, 1'b1, v);
      chk("h_front_porch", v, vid ? HT - HOFF : 0, vid);
      rd(8'h19, 1'b1, hp);
      chk("h_pulse_width", hp, hpw, 0);
      rd(8'h1B, 1'b1, v);
      chk("h_back_porch", v + (vid ? 16'h0000 : hp), vid ? HON - hpw : HT, 1);
      rd(8'h1D, 1'b1, v);
      chk("v_front_porch", v, vid ? VT - VOFF : 0, vid);
      rd(8'h1F, 1'b0, vp);
      chk("v_pulse_width", vp, VS, 0);
      rd(8'h20, 1'b1, v);
      chk("v_back_porch", v + (vid ? 16'h0000 : vp), vid ? VON - VS : VT, 1);
      rd(8'h22, 1'b1, v);
      chk("prev_v_front_porch", v, vid ? VT - VOFF : 0, vid);
      rd(8'h24, 1'b0, v);
      chk("prev_v_pulse_width", v, VS, 0);
      $display("measure done %0h %0d", ctrl, vid);
   endtask
   // length armed at a field start
   task automatic window_case(input int hs0, input int hl, input int vs0, input int vl, input bit inv);
      int wc = 0, sc = 0, first = -1;
      wr16(8'h11, 0);
      wr16(8'h15, 0);
      wr(8'h0B, inv ? 8'h80 : 8'h00);
      wr16(8'h0F, hs0);
      wr16(8'h13, vs0);
      wr16(8'h11, hl);
      @(posedge vsync_in);
      @(negedge mclk);
      wr16(8'h15, vl);
      @(posedge vsync_in);
      repeat (FIELD) begin
         @(negedge mclk);
         wc += int'(window_active === 1'b1);
         sc += int'(source_b_select === 1'b1);
         if (window_active === 1'b1 && first < 0) first = video_source_model_i.vc;
      end
      chk("window_cycles", 16'(wc), hl * vl, 0);
      chk("source_b_cycles", 16'(sc), inv ? FIELD - hl * vl : hl * vl, 0);
      if (hl * vl > 0) chk("window_first_line", 16'(first), vs0, 1);
      $display("window done %0d %0d %0d %0d", hs0, hl, vs0, vl);
   endtask
   task automatic complete_run();
      $display("compared %0d mismatches %0d", n_compared, err_count);
      if (err_count == 0 && n_compared > 0) $display("TEST PASSED");
      else $display("TEST FAILED");
      $finish;
   endtask
   // ****************************************
   // test sequence
   // ****************************************
   initial begin
      logic [15:0] v;
      int          d;
      void'($urandom(32'h0ec9386e));
      repeat (12) @(negedge mclk);
      reset_n = 1'b1;
      @(negedge mclk);
      for (int a = 8'h0F; a <= 8'h30; a++) begin
         rd(8'(a), 1'b0, v);
         chk("reset_or_unmapped", v, 0, 0);
      end
      wr(8'h17, 8'h5A);
      rd(8'h17, 1'b0, v);
      chk("read_only_write", v, 0, 0);
      for (int a = 8'h0F; a <= 8'h16; a++) begin
         d = $urandom % 256;
         wr(8'(a), 8'(d));
         rd(8'(a), 1'b0, v);
         chk("rw_readback", v, a[0] ? d : d & 8'h07, 0);
         if (a == 8'h11 || a == 8'h12) wr(8'(a), 8'h00);
      end
      $display("register test done");
      measure(8'h88, HS, 1'b1);
      @(posedge vsync_in);
      repeat (HS + 6) @(negedge mclk);
      wr(8'h00, 8'h88);
      for (int a = 8'h17; a <= 8'h24; a++) begin
         rd(8'(a), 1'b0, v);
         chk("cleared", v, 0, 0);
      end
      wr(8'h00, 8'h88);
      rd(8'h00, 1'b0, v);
      chk("control", v, 8'h08, 0);
      $display("clear test done");
      measure(8'hC8, HR, 1'b1);
      measure(8'h88, HS, 1'b0);
      video_en = 1'b1;
      for (int t = 0; t < 4; t++) window_case(10 + $urandom % 31, 1 + $urandom % 40, 2 + $urandom % 7, 1 + $urandom % 8, t[0]);
      window_case(20, 0, 3, 4, 1'b0);
      window_case(20, 30, 3, 0, 1'b1);
      complete_run();
   end
   initial begin
      #600000;
      err_count++;
      complete_run();
   end
endmodule
